/* File: board_decode_pkg.sv */
package board_decode_pkg;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFFSET      = 8'h00;
    localparam logic [7:0] PD_WAIT_OFFSET   = 8'h04;
    localparam logic [7:0] IO_WAIT_OFFSET   = 8'h08;
    localparam logic [7:0] STATUS_OFFSET    = 8'h0C;

    // control register fields
    localparam int CTRL_FLASH_DIS_BIT = 0;
    localparam int CTRL_OVERLAY_BIT   = 1;
    localparam int CTRL_CONFIG_BIT    = 2;
    localparam int CTRL_PRAM_BIT      = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // wait-state fields, three bits per space
    localparam int WAIT_W              = 3;
    localparam int PD_WAIT_PROG_LSB    = 0;
    localparam int PD_WAIT_DATA_LSB    = 3;
    localparam logic [2:0] WAIT_RESET  = 3'h7;
    localparam logic [2:0] IO_WAIT_MIN = 3'h3;

    // status register fields
    localparam int STAT_BOOT_JMP_BIT   = 0;
    localparam int STAT_PSEUDO_JMP_BIT = 1;
    localparam int STAT_ZERO_WAIT_BIT  = 2;
    localparam int STAT_IO_WAIT_LOW    = 3;
    localparam int STAT_SEL_LSB        = 4;

    // memory map boundaries
    localparam logic [15:0] PROG_SARAM_LO = 16'h2000;
    localparam logic [15:0] PROG_SARAM_HI = 16'h2BFF;
    localparam logic [15:0] PROG_B0_LO    = 16'hFE00;
    localparam logic [15:0] PROG_B0_HI    = 16'hFFFF;
    localparam logic [15:0] DATA_ONCHIP_HI = 16'h07FF;
    localparam logic [15:0] DATA_SARAM_LO = 16'h0800;
    localparam logic [15:0] DATA_SARAM_HI = 16'h2BFF;
    localparam logic [15:0] FLASH_HALF_LO = 16'h8000;
    localparam logic [15:0] PSEUDO_HI     = 16'h7FFF;
    localparam logic [15:0] ONBOARD_IO_LO = 16'h0000;
    localparam logic [15:0] ONBOARD_IO_HI = 16'h000F;
    localparam int FLASH_ADDR_W           = 15;

    // on-board peripheral stretch, in pclk cycles
    localparam int ONBOARD_IO_WAITS = 3;

    typedef enum logic [1:0] {
        RDY_IDLE    = 2'b00,
        RDY_STRETCH = 2'b01,
        RDY_HOLD    = 2'b11
    } ready_state_t;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    if (WIDTH < 1) begin : g_chk
        $error("pin_sync width must be at least one");
    end

    // a bit moves only once the last two stages agree
    assign level_next = (stage2_reg & stage3_reg) | (level_reg & (stage2_reg ^ stage3_reg));
    assign level_out  = level_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg  <= '0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= level_next;
        end
    end
endmodule
`default_nettype wire

/* File: io_ready_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module io_ready_gen
    import board_decode_pkg::*;
#(
    parameter int WAITS = ONBOARD_IO_WAITS
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic onboard_io,
    output logic      ready
);
    localparam int CW = $clog2(WAITS + 1);

    ready_state_t    state_reg;
    ready_state_t    state_next;
    logic [CW-1:0]   count_reg;
    logic [CW-1:0]   count_next;
    logic            ready_reg;
    logic            ready_next;
    logic            last_wait;

    if (WAITS < 1) begin : g_chk
        $error("io_ready_gen needs at least one stretch cycle");
    end

    assign last_wait = (count_reg == CW'(WAITS - 1));
    assign ready     = ready_reg;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        ready_next = 1'b1;
        case (state_reg)
            RDY_IDLE: begin
                if (onboard_io) begin
                    state_next = RDY_STRETCH;
                    count_next = '0;
                    ready_next = 1'b0;
                end
            end
            RDY_STRETCH: begin
                ready_next = 1'b0;
                count_next = count_reg + CW'(1);
                if (!onboard_io) begin
                    state_next = RDY_IDLE;
                    ready_next = 1'b1;
                end else if (last_wait) begin
                    state_next = RDY_HOLD;
                    ready_next = 1'b1;
                end
            end
            RDY_HOLD: begin
                // one stretch per strobe; wait for the strobe to end
                if (!onboard_io) begin
                    state_next = RDY_IDLE;
                end
            end
            default: begin
                state_next = RDY_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RDY_IDLE;
            count_reg <= '0;
            ready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            ready_reg <= ready_next;
        end
    end
endmodule
`default_nettype wire

/* File: board_memory_decode_wait.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - on-chip memory at the addressed location blocks every external select.
// R2 - program ram and data ram are separate 64k-word selects that never insert waits.
// R3 - the two byte-wide flash parts form one 32k-word image decoded in global data space.
// R4 - with the pseudo-boot jumper the flash is also decodable in program space.
// R5 - the boot-mode jumper drives the processor mode pin that picks the boot loader.
// R6 - the wait-state settings for every external space start at seven after reset.
// R7 - software must clear program and data wait states before ram runs without waits.
// R8 - ready stays high for all external program and data accesses.
// R9 - ready drops only for i/o accesses to on-board peripherals.
// R10 - software should keep the i/o wait-state count at three or more.
// R11 - the full 16-bit i/o address is passed to the parallel ports.
// R12 - flash answers in the upper half of global data space unless the disable bit is one.
// R13 - with pseudo-boot, program reads of the lower half hit flash and writes hit ram.
// R14 - with default jumpers and flash unused, every program location and every data location above 07FF maps to ram.
// R15 - program saram, data overlay and the configurable block, when enabled, block ram.
// R16 - upper-half data goes to flash only with global request and flash enabled.
module board_memory_decode_wait
    import board_decode_pkg::*;
#(
    parameter int IO_WAITS = ONBOARD_IO_WAITS
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [15:0]             cpu_addr,
    input  wire logic                    cpu_prog_strb,
    input  wire logic                    cpu_data_strb,
    input  wire logic                    cpu_io_strb,
    input  wire logic                    cpu_read,
    input  wire logic                    global_space_request,
    input  wire logic                    boot_mode_jumper,
    input  wire logic                    pseudo_boot_jumper,
    output logic                         boot_mode_pin,
    output logic                         prog_ram_sel,
    output logic                         data_ram_sel,
    output logic                         ram_write_en,
    output logic      [15:0]             ram_addr,
    output logic                         flash_sel,
    output logic      [FLASH_ADDR_W-1:0] flash_addr,
    output logic                         io_port_sel,
    output logic      [15:0]             io_port_addr,
    output logic                         cpu_ready
);
    import board_decode_pkg::*;

    // register state
    logic [3:0]  ctrl_reg;
    logic [3:0]  ctrl_next;
    logic [5:0]  pd_wait_reg;
    logic [5:0]  pd_wait_next;
    logic [2:0]  io_wait_reg;
    logic [2:0]  io_wait_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        pslverr_next;

    // jumpers after synchronising
    logic [1:0]  jumper_level;
    logic        boot_jmp;
    logic        pseudo_jmp;

    // apb decode
    logic        setup_phase;
    logic        access_done;
    logic        hit_ctrl;
    logic        hit_pd_wait;
    logic        hit_io_wait;
    logic        hit_status;
    logic        hit_any;
    logic        wr_ctrl;
    logic        wr_pd_wait;
    logic        wr_io_wait;

    // processor bus decode
    logic        flash_dis;
    logic        overlay_on;
    logic        config_on;
    logic        pram_on;
    logic        prog_onchip;
    logic        data_onchip;
    logic        upper_half;
    logic        lower_half;
    logic        flash_enabled;
    logic        global_flash;
    logic        pseudo_flash;
    logic        ext_prog;
    logic        ext_data;

    // selects and ready
    logic        sel_prog_ram;
    logic        sel_data_ram;
    logic        sel_flash;
    logic        onboard_io;
    logic        sel_io_port;
    logic        ready_wire;

    // status helpers
    logic        zero_wait_ok;
    logic        io_wait_low;
    logic [31:0] status_word;

    // decode output registers
    logic                    prog_ram_reg;
    logic                    data_ram_reg;
    logic                    ram_we_reg;
    logic [15:0]             ram_addr_reg;
    logic                    flash_reg;
    logic [FLASH_ADDR_W-1:0] flash_addr_reg;
    logic                    io_port_reg;
    logic [15:0]             io_addr_reg;
    logic                    boot_pin_reg;

    if (IO_WAITS < 1) begin : g_chk
        $error("IO_WAITS must be at least one");
    end

    pin_sync #(
        .WIDTH (2)
    ) u_jumpers (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    ({pseudo_boot_jumper, boot_mode_jumper}),
        .level_out (jumper_level)
    );

    // a jumper move counts once the synchroniser settles
    assign boot_jmp   = jumper_level[0];
    assign pseudo_jmp = jumper_level[1];

    // apb slave: one wait-free access phase, data prepared during setup
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_reg;

    assign hit_ctrl    = (paddr == CTRL_OFFSET);
    assign hit_pd_wait = (paddr == PD_WAIT_OFFSET);
    assign hit_io_wait = (paddr == IO_WAIT_OFFSET);
    assign hit_status  = (paddr == STATUS_OFFSET);
    assign hit_any     = hit_ctrl || hit_pd_wait || hit_io_wait || hit_status;

    assign wr_ctrl     = access_done && pwrite && hit_ctrl;
    assign wr_pd_wait  = access_done && pwrite && hit_pd_wait;
    assign wr_io_wait  = access_done && pwrite && hit_io_wait;

    // only a completing write to a match changes a register
    assign ctrl_next    = wr_ctrl ? pwdata[3:0] : ctrl_reg;
    assign pd_wait_next = wr_pd_wait ? pwdata[5:0] : pd_wait_reg;
    assign io_wait_next = wr_io_wait ? pwdata[2:0] : io_wait_reg;

    // R7 zero wait check
    assign zero_wait_ok = (pd_wait_reg == 6'h00);

    // R10 low i/o wait flag
    assign io_wait_low  = (io_wait_reg < IO_WAIT_MIN);

    // status shows registered selects, a clock late
    assign status_word = {24'h000000,
                          io_port_reg, flash_reg, data_ram_reg, prog_ram_reg,
                          io_wait_low, zero_wait_ok, pseudo_jmp, boot_jmp};

    // read data is taken at setup and holds after
    assign prdata_next = !setup_phase ? prdata_reg :
                         (pwrite || !hit_any) ? 32'h00000000 :
                         hit_ctrl    ? {28'h0000000, ctrl_reg} :
                         hit_pd_wait ? {26'h0000000, pd_wait_reg} :
                         hit_io_wait ? {29'h00000000, io_wait_reg} :
                         status_word;
    // the error clears as the failing access completes
    assign pslverr_next = setup_phase ? !hit_any : (pslverr_reg && !access_done);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= CTRL_RESET;
            // R6 seven waits at start
            pd_wait_reg <= {WAIT_RESET, WAIT_RESET};
            io_wait_reg <= WAIT_RESET;
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            pd_wait_reg <= pd_wait_next;
            io_wait_reg <= io_wait_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= setup_phase;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // processor memory decode
    // shadow bits must match the processor's setting
    assign flash_dis  = ctrl_reg[CTRL_FLASH_DIS_BIT];
    assign overlay_on = ctrl_reg[CTRL_OVERLAY_BIT];
    assign config_on  = ctrl_reg[CTRL_CONFIG_BIT];
    assign pram_on    = ctrl_reg[CTRL_PRAM_BIT];

    // R15 on-chip blocks by config
    assign prog_onchip = (pram_on && in_range(cpu_addr, PROG_SARAM_LO, PROG_SARAM_HI)) ||
                         (config_on && in_range(cpu_addr, PROG_B0_LO, PROG_B0_HI));
    assign data_onchip = in_range(cpu_addr, 16'h0000, DATA_ONCHIP_HI) ||
                         (overlay_on && in_range(cpu_addr, DATA_SARAM_LO, DATA_SARAM_HI));

    assign upper_half    = in_range(cpu_addr, FLASH_HALF_LO, 16'hFFFF);
    assign lower_half    = in_range(cpu_addr, 16'h0000, PSEUDO_HI);
    // R12 disable bit turns flash off
    assign flash_enabled = !flash_dis;

    // R16 global request gates flash
    assign global_flash  = cpu_data_strb && upper_half && global_space_request && flash_enabled;

    // R13 pseudo-boot reads from flash
    // on-chip program memory wins over the flash too
    assign pseudo_flash  = ext_prog && cpu_read && lower_half && pseudo_jmp && flash_enabled;

    // R1 on-chip wins over external
    assign ext_prog = cpu_prog_strb && !prog_onchip;
    assign ext_data = cpu_data_strb && !data_onchip;

    // R14 everything else maps to ram
    assign sel_prog_ram = ext_prog && !pseudo_flash;
    assign sel_data_ram = ext_data && !global_flash;

    // R3 one flash word from two byte parts
    assign sel_flash    = pseudo_flash || global_flash;

    // other ports rely on the processor's own waits
    // R9 on-board peripheral range
    assign onboard_io  = cpu_io_strb && in_range(cpu_addr, ONBOARD_IO_LO, ONBOARD_IO_HI);
    assign sel_io_port = cpu_io_strb && !onboard_io;

    // R8 R9 ready stretch only on-board
    io_ready_gen #(
        .WAITS (IO_WAITS)
    ) u_ready (
        .pclk       (pclk),
        .presetn    (presetn),
        .onboard_io (onboard_io),
        .ready      (ready_wire)
    );

    // registered so the selects never glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_ram_reg   <= 1'b0;
            data_ram_reg   <= 1'b0;
            ram_we_reg     <= 1'b0;
            ram_addr_reg   <= 16'h0000;
            flash_reg      <= 1'b0;
            flash_addr_reg <= '0;
            io_port_reg    <= 1'b0;
            io_addr_reg    <= 16'h0000;
            boot_pin_reg   <= 1'b0;
        end else begin
            // R2 separate program and data ram
            prog_ram_reg   <= sel_prog_ram;
            data_ram_reg   <= sel_data_ram;

            // R13 pseudo-boot writes still go to ram
            ram_we_reg     <= (sel_prog_ram || sel_data_ram) && !cpu_read;
            ram_addr_reg   <= cpu_addr;
            flash_reg      <= sel_flash;
            flash_addr_reg <= cpu_addr[FLASH_ADDR_W-1:0];

            // R11 full i/o address to ports
            io_port_reg    <= sel_io_port;
            io_addr_reg    <= cpu_addr;

            // R5 jumper to mode pin
            boot_pin_reg   <= boot_jmp;
        end
    end

    assign prog_ram_sel  = prog_ram_reg;
    assign data_ram_sel  = data_ram_reg;
    assign ram_write_en  = ram_we_reg;
    assign ram_addr      = ram_addr_reg;

    assign flash_sel     = flash_reg;
    assign flash_addr    = flash_addr_reg;
    assign io_port_sel   = io_port_reg;
    assign io_port_addr  = io_addr_reg;

    assign boot_mode_pin = boot_pin_reg;
    assign cpu_ready     = ready_wire;
endmodule
`default_nettype wire

/* File: board_memory_decode_wait_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module board_memory_decode_wait_checker
    import board_decode_pkg::*;
#(
    parameter int IO_WAITS = ONBOARD_IO_WAITS
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic [7:0]              paddr,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic [15:0]             cpu_addr,
    input wire logic                    cpu_prog_strb,
    input wire logic                    cpu_data_strb,
    input wire logic                    cpu_io_strb,
    input wire logic                    cpu_read,
    input wire logic                    global_space_request,
    input wire logic                    boot_mode_jumper,
    input wire logic                    boot_mode_pin,
    input wire logic                    prog_ram_sel,
    input wire logic                    data_ram_sel,
    input wire logic                    ram_write_en,
    input wire logic                    flash_sel,
    input wire logic [FLASH_ADDR_W-1:0] flash_addr,
    input wire logic                    io_port_sel,
    input wire logic [15:0]             io_port_addr,
    input wire logic                    cpu_ready
);
    logic [7:0] low_cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // length of the not-ready stretch, judged when ready comes back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= cpu_ready ? 8'h00 : low_cnt + 8'h01;
        end
    end
    onchip_block_a: assert property (
        cpu_data_strb && cpu_addr <= DATA_ONCHIP_HI |=> !data_ram_sel && !flash_sel)
        else $error("external select on on-chip data");
    ram_write_a: assert property (
        cpu_prog_strb && !cpu_read && cpu_addr inside {[16'h3000:16'hFDFF]} |=> prog_ram_sel && ram_write_en)
        else $error("program write missed ram");
    flash_addr_a: assert property (
        flash_sel |-> {1'b0, flash_addr} == ($past(cpu_addr) & 16'h7FFF) && !data_ram_sel)
        else $error("flash address or select clash");
    flash_gate_a: assert property (
        cpu_data_strb && cpu_addr[15] && !global_space_request |=> data_ram_sel && !flash_sel)
        else $error("flash selected without global request");
    mem_ready_a: assert property (
        (cpu_prog_strb || cpu_data_strb) [*2] |-> cpu_ready)
        else $error("memory access stretched");
    ready_cause_a: assert property (
        !cpu_ready |-> $past(cpu_io_strb) && $past(cpu_addr) <= ONBOARD_IO_HI)
        else $error("ready low outside on-board io");
    stretch_len_a: assert property (
        $rose(cpu_ready) |-> low_cnt == IO_WAITS)
        else $error("wrong stretch length");
    io_sel_a: assert property (
        cpu_io_strb && cpu_addr > ONBOARD_IO_HI |=> io_port_sel && io_port_addr == $past(cpu_addr))
        else $error("io address not passed");
    boot_pin_a: assert property (
        $stable(boot_mode_jumper) [*5] |-> boot_mode_pin == boot_mode_jumper)
        else $error("mode pin not following jumper");
    apb_ready_a: assert property (
        psel && !penable && paddr[1:0] == 2'b00 |=> pready && pslverr == (paddr > STATUS_OFFSET))
        else $error("apb answer wrong");
    cover property (flash_sel);
    cover property ($fell(cpu_ready));
    cover property (ram_write_en && prog_ram_sel);
endmodule
bind board_memory_decode_wait board_memory_decode_wait_checker #(.IO_WAITS(IO_WAITS)) checker_i (.*);
`default_nettype wire

/* File: cpu_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input  wire logic        pclk,
    input  wire logic        cpu_ready,
    output logic      [15:0] cpu_addr,
    output logic             cpu_prog_strb,
    output logic             cpu_data_strb,
    output logic             cpu_io_strb,
    output logic             cpu_read,
    output logic             global_space_request
);
    initial begin
        cpu_addr = 16'h0000;
        {cpu_io_strb, cpu_data_strb, cpu_prog_strb} = 3'b000;
        cpu_read = 1'b1;
        global_space_request = 1'b0;
    end
    // decode is registered, so outputs are looked at one edge after launch
    task automatic start(input logic [2:0] sp, input logic [15:0] a, input logic rd, input logic gr);
        @(posedge pclk);
        {cpu_io_strb, cpu_data_strb, cpu_prog_strb} <= sp;
        cpu_addr <= a;
        cpu_read <= rd;
        global_space_request <= gr;
        @(posedge pclk);
        #1;
    endtask
    task automatic stop();
        @(posedge pclk);
        while (cpu_ready !== 1'b1) @(posedge pclk);
        {cpu_io_strb, cpu_data_strb, cpu_prog_strb} <= 3'b000;
        // a released bus must not look like the last access
        cpu_addr <= ~cpu_addr;
        cpu_read <= ~cpu_read;
    endtask
endmodule
`default_nettype wire

/* File: test_board_memory_decode_wait.sv */
`timescale 1ns/1ps
`default_nettype none
module test_board_memory_decode_wait;
    import board_decode_pkg::*;
    localparam int IOW = 3;
    // {ctrl, space io/data/prog, read, gsr, selects io/flash/data/prog/wen, address}
    localparam logic [29:0] MAP [12] = '{
        {4'h0, 3'b001, 2'b10, 5'b00010, 16'h0100}, {4'h0, 3'b010, 2'b00, 5'b00101, 16'h3000},
        {4'h0, 3'b010, 2'b10, 5'b00100, 16'h9000}, {4'h0, 3'b010, 2'b11, 5'b01000, 16'h9000},
        {4'h1, 3'b010, 2'b11, 5'b00100, 16'h9000}, {4'h0, 3'b010, 2'b10, 5'b00000, 16'h0400},
        {4'h0, 3'b010, 2'b10, 5'b00100, 16'h0900}, {4'h2, 3'b010, 2'b10, 5'b00000, 16'h0900},
        {4'h8, 3'b001, 2'b10, 5'b00000, 16'h2100}, {4'h0, 3'b001, 2'b10, 5'b00010, 16'h2100},
        {4'h4, 3'b001, 2'b10, 5'b00000, 16'hFF00}, {4'h0, 3'b001, 2'b00, 5'b00011, 16'hFF00}};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        boot_mode_jumper = 1'b0, pseudo_boot_jumper = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, boot_mode_pin, prog_ram_sel, data_ram_sel, ram_write_en;
    logic        flash_sel, io_port_sel, cpu_ready, cpu_prog_strb, cpu_data_strb, cpu_io_strb;
    logic        cpu_read, global_space_request;
    logic [15:0] ram_addr, io_port_addr, cpu_addr;
    logic [14:0] flash_addr;
    int          err_total = 0, num_checks = 0;
    board_memory_decode_wait #(.IO_WAITS(IOW)) board_memory_decode_wait_i (.*);
    cpu_bus_model cpu_bus_model_i (.*);
    always #12.5 pclk = ~pclk;
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        ck(n, e, rd);
    endtask
    task automatic sel(input logic [4:0] e);
        ck("selects", {27'h0, e}, {27'h0, io_port_sel, flash_sel, data_ram_sel, prog_ram_sel, ram_write_en});
    endtask
    task automatic t_reset();
        rchk(CTRL_OFFSET, {28'h0, CTRL_RESET}, "ctrl");
        rchk(PD_WAIT_OFFSET, {26'h0, WAIT_RESET, WAIT_RESET}, "pd_wait");
        rchk(IO_WAIT_OFFSET, {29'h0, WAIT_RESET}, "io_wait");
        rchk(STATUS_OFFSET, 32'h0, "status");
    endtask
    task automatic t_regs();
        apb(1'b1, PD_WAIT_OFFSET, 32'h0);
        rchk(STATUS_OFFSET, 32'h4, "zero_wait");
        apb(1'b1, IO_WAIT_OFFSET, 32'h2);
        rchk(STATUS_OFFSET, 32'hC, "io_wait_low");
        apb(1'b1, IO_WAIT_OFFSET, {29'h0, IO_WAIT_MIN});
        apb(1'b1, STATUS_OFFSET, 32'hFF);
        rchk(STATUS_OFFSET, 32'h4, "status_ro");
        rchk(8'h10, 32'h0, "unmapped_data");
        ck("unmapped_err", 32'h1, {31'h0, er});
    endtask
    task automatic t_map();
        logic [29:0] m;
        for (int i = 0; i < 12; i++) begin
            m = MAP[i];
            apb(1'b1, CTRL_OFFSET, {28'h0, m[29:26]});
            cpu_bus_model_i.start(m[25:23], m[15:0], m[22], m[21]);
            sel(m[20:16]);
            if (m[18] || m[17]) ck("ram_addr", {16'h0, m[15:0]}, {16'h0, ram_addr});
            if (m[19]) ck("flash_addr", {17'h0, m[14:0]}, {17'h0, flash_addr});
            ck("cpu_ready", 32'h1, {31'h0, cpu_ready});
            cpu_bus_model_i.stop();
        end
    endtask
    task automatic t_pseudo();
        @(posedge pclk);
        pseudo_boot_jumper <= 1'b1;
        repeat (5) @(posedge pclk);
        rchk(STATUS_OFFSET, 32'h6, "status_pseudo");
        cpu_bus_model_i.start(3'b001, 16'h0100, 1'b1, 1'b0);
        sel(5'b01000);
        ck("flash_addr", 32'h100, {17'h0, flash_addr});
        cpu_bus_model_i.stop();
        cpu_bus_model_i.start(3'b001, 16'h0100, 1'b0, 1'b0);
        sel(5'b00011);
        cpu_bus_model_i.stop();
        apb(1'b1, CTRL_OFFSET, 32'h1);
        cpu_bus_model_i.start(3'b001, 16'h0100, 1'b1, 1'b0);
        sel(5'b00010);
        cpu_bus_model_i.stop();
        apb(1'b1, CTRL_OFFSET, 32'h0);
        pseudo_boot_jumper <= 1'b0;
    endtask
    task automatic t_boot();
        @(posedge pclk);
        boot_mode_jumper <= 1'b1;
        repeat (5) @(posedge pclk);
        #1;
        ck("boot_mode_pin", 32'h1, {31'h0, boot_mode_pin});
        rchk(STATUS_OFFSET, 32'h5, "status_boot");
        boot_mode_jumper <= 1'b0;
        repeat (5) @(posedge pclk);
        #1;
        ck("boot_mode_pin", 32'h0, {31'h0, boot_mode_pin});
    endtask
    task automatic t_io();
        int n;
        n = 0;
        cpu_bus_model_i.start(3'b100, 16'h0005, 1'b1, 1'b0);
        ck("io_port_addr", 32'h5, {16'h0, io_port_addr});
        sel(5'b00000);
        while (cpu_ready === 1'b0 && n < 10) begin
            n++;
            @(posedge pclk);
            #1;
        end
        ck("wait_cycles", IOW, n);
        cpu_bus_model_i.stop();
        cpu_bus_model_i.start(3'b100, 16'h1234, 1'b0, 1'b0);
        sel(5'b10000);
        ck("io_port_addr", 32'h1234, {16'h0, io_port_addr});
        ck("cpu_ready", 32'h1, {31'h0, cpu_ready});
        cpu_bus_model_i.stop();
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_map();
        t_pseudo();
        t_boot();
        t_io();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
